/* File: logic/event_serial_pkg.sv */
// shared constants and state types for the event counter and serial port block
// assumes an APB slave with 32-bit data; register index times four gives the byte address
package event_serial_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;

    // register indexes; byte address is the index times four
    localparam logic [3:0] IDX_TIMER_A_COUNT_LOW = 4'h4;
    localparam logic [3:0] IDX_TIMER_A_COUNT_HIGH = 4'h5;
    localparam logic [3:0] IDX_TIMER_B_COUNT_LOW = 4'h6;
    localparam logic [3:0] IDX_TIMER_B_COUNT_HIGH = 4'h7;
    localparam logic [3:0] IDX_EV_LO = 4'h8;
    localparam logic [3:0] IDX_EV_MID = 4'h9;
    localparam logic [3:0] IDX_EV_HI = 4'hA;
    localparam logic [3:0] IDX_SERIAL = 4'hC;
    localparam logic [3:0] IDX_STATUS = 4'hD;
    localparam logic [3:0] IDX_CTRL_A = 4'hE;
    localparam logic [3:0] IDX_CTRL_B = 4'hF;

    // control register fields
    localparam int CTL_START = 0;
    localparam int CTL_ONESHOT = 3;
    localparam int CTL_LOAD = 4;
    localparam int CTL_SER_TX = 6;
    localparam int CTL_ALARM_SEL = 7;

    // status register fields
    localparam int ST_TA = 0;
    localparam int ST_TB = 1;
    localparam int ST_ALARM = 2;
    localparam int ST_SERIAL = 3;
    localparam int ST_W = 4;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [15:0] TIMER_ONE = 16'h0001;
    localparam logic [23:0] EVENT_ONE = 24'h000001;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] latch;
        logic start;
        logic one_shot;
    } timer_t;

    typedef struct packed {
        timer_t ta;
        timer_t tb;
        logic serial_tx_dir;
        logic alarm_write_select;
        logic [23:0] events;
        logic [23:0] alarm;
        logic [23:0] snapshot;
        logic frozen;
        logic halted;
        logic [2:0] ev_sync;
        logic [2:0] sclk_sync;
        logic [1:0] sdat_sync;
        logic [7:0] shifter;
        logic [7:0] serial_byte_register;
        logic [2:0] bit_count;
        logic tx_pending;
        logic tx_active;
        logic clk_low;
        logic data_low;
        logic [ST_W-1:0] status;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic alarm_pulse;
        logic serial_pulse;
        logic pin_low_level;
    } state_t;

    localparam state_t STATE_RESET = '0;

endpackage

/* File: logic/event_serial_port.sv */
// event counter, two interval timers and synchronous serial port behind an APB slave
// assumes event and shift pins are asynchronous to pclk; the shift pins are open-drain
// with pull-ups outside, so the pin value driven is always low and only the enable moves
`timescale 1ns/100ps

module event_serial_port
    import event_serial_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic time_of_day_counter,
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    output logic alarm_event,
    output logic serial_event
);

    state_t s;
    state_t next_s;

    // one step of an interval timer counting the phase clock
    function automatic timer_t timer_next(input timer_t t, input logic wr_lo,
                                          input logic wr_hi, input logic wr_ctl,
                                          input logic [7:0] wdata, output logic underflow);
        timer_t n;
        n = t;
        underflow = 1'b0;
        if (t.start) begin
            if (t.count == '0) begin
                underflow = 1'b1;
                n.count = t.latch;
                if (t.one_shot) begin
                    n.start = 1'b0;
                end
            end else begin
                n.count = t.count - TIMER_ONE;
            end
        end
        // writes land in the latch; the load bit, or a high-byte write to a stopped or one-shot timer, also sets the counter
        if (wr_lo) begin
            n.latch[7:0] = wdata;
        end
        if (wr_hi) begin
            n.latch[15:8] = wdata;
            // a stopped or one-shot timer takes the latch at once
            if (!t.start || t.one_shot) begin
                n.count = {wdata, n.latch[7:0]};
            end
            if (t.one_shot) begin
                n.start = 1'b1;
            end
        end
        if (wr_ctl) begin
            n.start = wdata[CTL_START];
            n.one_shot = wdata[CTL_ONESHOT];
            if (wdata[CTL_LOAD]) begin
                n.count = n.latch;
            end
        end
        return n;
    endfunction

    // true for every index that holds a register
    function automatic logic is_mapped(input logic [3:0] idx);
        return (idx >= IDX_TIMER_A_COUNT_LOW) && (idx != 4'hB);
    endfunction

    // next state of the whole block
    always_comb begin
        logic fetch;
        logic done;
        logic wr;
        logic [3:0] idx;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic ua;
        logic ub;
        logic ev_edge;
        logic sclk_rise;
        logic ev_wr;
        logic [23:0] ev_live;
        logic [23:0] ev_view;
        logic [ST_W-1:0] set_bits;
        fetch = 1'b0;
        done = 1'b0;
        wr = 1'b0;
        idx = paddr[5:2];
        wbyte = pwdata[7:0];
        rbyte = 8'h00;
        ua = 1'b0;
        ub = 1'b0;
        ev_edge = 1'b0;
        sclk_rise = 1'b0;
        ev_wr = 1'b0;
        ev_live = '0;
        ev_view = '0;
        set_bits = '0;
        next_s = s;
        next_s.alarm_pulse = 1'b0;
        next_s.serial_pulse = 1'b0;

        // one wait state: data is fetched on the first access edge, pready follows
        fetch = psel && penable && !s.pready;
        done = psel && penable && s.pready;
        wr = done && pwrite;
        next_s.pready = fetch;
        next_s.pslverr = fetch && !is_mapped(idx);

        // pins pass two flops before anything looks at them
        next_s.ev_sync = {s.ev_sync[1:0], time_of_day_counter};
        next_s.sclk_sync = {s.sclk_sync[1:0], shift_clock_pin_in};
        next_s.sdat_sync = {s.sdat_sync[0], serial_data_pin_in};
        ev_edge = s.ev_sync[1] && !s.ev_sync[2];
        sclk_rise = s.sclk_sync[1] && !s.sclk_sync[2];

        // interval timers
        next_s.ta = timer_next(s.ta, wr && idx == IDX_TIMER_A_COUNT_LOW, wr && idx == IDX_TIMER_A_COUNT_HIGH,
                               wr && idx == IDX_CTRL_A, wbyte, ua);
        next_s.tb = timer_next(s.tb, wr && idx == IDX_TIMER_B_COUNT_LOW, wr && idx == IDX_TIMER_B_COUNT_HIGH,
                               wr && idx == IDX_CTRL_B, wbyte, ub);
        if (wr && idx == IDX_CTRL_A) begin
            next_s.serial_tx_dir = wbyte[CTL_SER_TX];
            next_s.bit_count = '0;
        end
        if (wr && idx == IDX_CTRL_B) begin
            next_s.alarm_write_select = wbyte[CTL_ALARM_SEL];
        end

        // event counter keeps counting whatever the output freeze does
        ev_live = s.events + EVENT_ONE;
        if (ev_edge && !s.halted) begin
            next_s.events = ev_live;
            if (ev_live == s.alarm) begin
                next_s.alarm_pulse = 1'b1;
                set_bits[ST_ALARM] = 1'b1;
            end
        end

        // event writes: counter or alarm, and the counter stops until the low byte
        ev_wr = wr && (idx == IDX_EV_LO || idx == IDX_EV_MID || idx == IDX_EV_HI);
        if (ev_wr) begin
            next_s.halted = (idx != IDX_EV_LO);
            if (s.alarm_write_select) begin
                unique case (idx)
                    IDX_EV_LO: next_s.alarm[7:0] = wbyte;
                    IDX_EV_MID: next_s.alarm[15:8] = wbyte;
                    default: next_s.alarm[23:16] = wbyte;
                endcase
            end else begin
                unique case (idx)
                    IDX_EV_LO: next_s.events[7:0] = wbyte;
                    IDX_EV_MID: next_s.events[15:8] = wbyte;
                    default: next_s.events[23:16] = wbyte;
                endcase
            end
        end

        // reads of the event bytes never see the alarm
        ev_view = s.frozen ? s.snapshot : s.events;
        if (fetch && !pwrite && idx == IDX_EV_HI && !s.frozen) begin
            next_s.frozen = 1'b1;
            next_s.snapshot = s.events;
        end
        if (fetch && !pwrite && idx == IDX_EV_LO) begin
            next_s.frozen = 1'b0;
        end

        if (ua) begin
            set_bits[ST_TA] = 1'b1;
        end
        if (ub) begin
            set_bits[ST_TB] = 1'b1;
        end

        // byte written to the serial register waits for the shifter
        if (wr && idx == IDX_SERIAL) begin
            next_s.serial_byte_register = wbyte;
            next_s.tx_pending = s.serial_tx_dir;
        end

        if (!s.serial_tx_dir) begin
            // receive: the far end owns the clock, both pins are released
            next_s.tx_active = 1'b0;
            next_s.tx_pending = 1'b0;
            next_s.clk_low = 1'b0;
            next_s.data_low = 1'b0;
            if (sclk_rise) begin
                next_s.shifter = {s.shifter[6:0], s.sdat_sync[1]};
                next_s.bit_count = s.bit_count + 3'h1;
                if (s.bit_count == LAST_BIT) begin
                    next_s.serial_byte_register = {s.shifter[6:0], s.sdat_sync[1]};
                    next_s.serial_pulse = 1'b1;
                    set_bits[ST_SERIAL] = 1'b1;
                end
            end
        end else if (ua && s.ta.start && !s.ta.one_shot) begin
            // transmit: each continuous-mode timer A underflow is one half period of the shift clock
            if (!s.tx_active) begin
                if (s.tx_pending) begin
                    next_s.shifter = s.serial_byte_register;
                    next_s.tx_pending = 1'b0;
                    next_s.tx_active = 1'b1;
                    next_s.bit_count = '0;
                end
            end else if (!s.clk_low) begin
                // falling edge: the next bit appears and holds for a full period
                next_s.clk_low = 1'b1;
                next_s.data_low = !s.shifter[7];
            end else begin
                next_s.clk_low = 1'b0;
                next_s.shifter = {s.shifter[6:0], 1'b0};
                next_s.bit_count = s.bit_count + 3'h1;
                if (s.bit_count == LAST_BIT) begin
                    next_s.serial_pulse = 1'b1;
                    set_bits[ST_SERIAL] = 1'b1;
                    if (s.tx_pending) begin
                        next_s.shifter = s.serial_byte_register;
                        next_s.tx_pending = 1'b0;
                    end else begin
                        // clock rests high, data keeps the last bit
                        next_s.tx_active = 1'b0;
                    end
                end
            end
        end

        // status bits are write-one-to-clear; a new event in that cycle still sets
        if (wr && idx == IDX_STATUS) begin
            next_s.status = s.status & ~wbyte[ST_W-1:0];
        end
        next_s.status = next_s.status | set_bits;

        // read data
        unique case (idx)
            IDX_TIMER_A_COUNT_LOW: rbyte = s.ta.count[7:0];
            IDX_TIMER_A_COUNT_HIGH: rbyte = s.ta.count[15:8];
            IDX_TIMER_B_COUNT_LOW: rbyte = s.tb.count[7:0];
            IDX_TIMER_B_COUNT_HIGH: rbyte = s.tb.count[15:8];
            IDX_EV_LO: rbyte = ev_view[7:0];
            IDX_EV_MID: rbyte = ev_view[15:8];
            IDX_EV_HI: rbyte = ev_view[23:16];
            IDX_SERIAL: rbyte = s.serial_byte_register;
            IDX_STATUS: rbyte = {4'h0, s.status};
            IDX_CTRL_A: rbyte = {1'b0, s.serial_tx_dir, 2'b00, s.ta.one_shot, 2'b00, s.ta.start};
            IDX_CTRL_B: rbyte = {s.alarm_write_select, 3'b000, s.tb.one_shot, 2'b00,
                                 s.tb.start};
            default: rbyte = 8'h00;
        endcase
        if (fetch) begin
            next_s.prdata = pwrite ? '0 : {24'h000000, rbyte};
        end
    end

    // the whole state sits in one register; the shift clock synchroniser starts at
    // the wire's pulled-up idle level so no false rising edge follows reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= STATE_RESET;
            s.sclk_sync <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    // open-drain: only the enable moves, the driven level stays low
    assign shift_clock_pin_out = s.pin_low_level;
    assign serial_data_pin_out = s.pin_low_level;
    assign shift_clock_pin_oe = s.clk_low;
    assign serial_data_pin_oe = s.data_low;
    assign alarm_event = s.alarm_pulse;
    assign serial_event = s.serial_pulse;

endmodule

/* File: tb/serial_peer.sv */
// far-side device on the open-drain shift clock and data wires
// assumes the bench resolves the wires with pull-ups from every pull-low enable
`timescale 1ns/100ps
module serial_peer (
    input wire logic sck,
    input wire logic sda,
    output logic sck_oe,
    output logic sda_oe,
    output logic [7:0] got
);
    initial begin
        sck_oe = 1'b0;
        sda_oe = 1'b0;
        got = 8'h00;
    end
    // listener: shift in on each rising wire clock, first bit lands at the top
    always @(posedge sck) begin
        got <= {got[6:0], sda};
    end
    // master role: 400 ns clock only inside the frame, data moves while the clock is low
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sck_oe = 1'b1;
            sda_oe = !b[i];
            #200;
            sck_oe = 1'b0;
            #200;
        end
        sda_oe = 1'b0; // released data floats up to the pull-up level
    endtask
endmodule

/* File: tb/event_serial_checker.sv */
// port checker for the event counter and serial port block
// assumes timer A runs with latch 2 while transmitting, so a clock half is 3 pclk
`timescale 1ns/100ps
module event_serial_checker
    import event_serial_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic time_of_day_counter,
    input wire logic shift_clock_pin_in,
    input wire logic shift_clock_pin_out,
    input wire logic shift_clock_pin_oe,
    input wire logic serial_data_pin_in,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe,
    input wire logic alarm_event,
    input wire logic serial_event
);
    logic tod_q;
    logic [3:0] since_tod;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the last event pin rise; saturates so a long quiet spell never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tod_q <= 1'b0;
            since_tod <= 4'hF;
        end else begin
            tod_q <= time_of_day_counter;
            if (time_of_day_counter && !tod_q) begin
                since_tod <= 4'h0;
            end else if (since_tod != 4'hF) begin
                since_tod <= since_tod + 4'h1;
            end
        end
    end
    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    AST_BYTE_WIDE: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above bit 7");
    AST_UNMAPPED: assert property (pready |->
        pslverr == (paddr[5:4] == 2'h0 || paddr[5:2] == 4'hB)) else $error("bad error flag");
    AST_ALARM_CAUSE: assert property (alarm_event |-> since_tod <= 4'h6)
        else $error("alarm without event edge");
    AST_ALARM_PULSE: assert property (alarm_event |=> !alarm_event)
        else $error("alarm pulse too long");
    AST_SERIAL_PULSE: assert property (serial_event |=> !serial_event)
        else $error("serial pulse too long");
    AST_END_CLOCK_HIGH: assert property (serial_event |-> !shift_clock_pin_oe)
        else $error("byte end with clock low");
    AST_DATA_ON_FALL: assert property ($changed(serial_data_pin_oe) |->
        $rose(shift_clock_pin_oe)) else $error("data moved off a falling clock");
    AST_HALF_LOW: assert property ($rose(shift_clock_pin_oe) |->
        shift_clock_pin_oe [*3] ##1 !shift_clock_pin_oe) else $error("low half wrong");
    AST_HALF_HIGH: assert property ($fell(shift_clock_pin_oe) |->
        !shift_clock_pin_oe [*3]) else $error("high half short");
    AST_OPEN_DRAIN: assert property (!shift_clock_pin_out && !serial_data_pin_out)
        else $error("pin driven high");
endmodule
bind event_serial_port event_serial_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .time_of_day_counter, .shift_clock_pin_in,
    .shift_clock_pin_out, .shift_clock_pin_oe, .serial_data_pin_in, .serial_data_pin_out,
    .serial_data_pin_oe, .alarm_event, .serial_event);

/* File: tb/test_event_serial_port.sv */
// self-checking bench: register walk, event counter, serial receive and transmit
// assumes the peer model on the open-drain wires and the bound port checker
`timescale 1ns/100ps
module test_event_serial_port
    import event_serial_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [3:0] idx;
        logic [7:0] d;
        logic [7:0] exp;
        logic err;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 6'h00;
    logic [DATA_W-1:0] pwdata = 32'h00000000;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, rerr, alarm_event, serial_event, peer_sck_oe, peer_sda_oe;
    logic time_of_day_counter = 1'b0;
    logic shift_clock_pin_in, shift_clock_pin_out, shift_clock_pin_oe;
    logic serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe;
    logic [7:0] peer_got, rd;
    int n_mismatch = 0, n_tests = 0, n_alarm = 0, n_ser = 0, k;
    row_t rows [19] = '{
        '{1'b1, IDX_TIMER_A_COUNT_LOW, 8'h02, 8'h00, 1'b0}, '{1'b1, IDX_TIMER_A_COUNT_HIGH, 8'h00, 8'h00, 1'b0},
        '{1'b0, IDX_TIMER_A_COUNT_LOW, 8'h00, 8'h02, 1'b0}, '{1'b1, IDX_TIMER_A_COUNT_LOW, 8'h09, 8'h00, 1'b0},
        '{1'b0, IDX_TIMER_A_COUNT_LOW, 8'h00, 8'h02, 1'b0}, '{1'b1, IDX_TIMER_A_COUNT_LOW, 8'h02, 8'h00, 1'b0},
        '{1'b0, IDX_TIMER_A_COUNT_HIGH, 8'h00, 8'h00, 1'b0}, '{1'b1, IDX_TIMER_B_COUNT_LOW, 8'h34, 8'h00, 1'b0},
        '{1'b1, IDX_TIMER_B_COUNT_HIGH, 8'h12, 8'h00, 1'b0}, '{1'b0, IDX_TIMER_B_COUNT_LOW, 8'h00, 8'h34, 1'b0},
        '{1'b0, IDX_TIMER_B_COUNT_HIGH, 8'h00, 8'h12, 1'b0}, '{1'b0, 4'h0, 8'h00, 8'h00, 1'b1},
        '{1'b1, 4'hB, 8'h55, 8'h00, 1'b1}, '{1'b1, IDX_CTRL_B, 8'h80, 8'h00, 1'b0},
        '{1'b1, IDX_EV_LO, 8'h05, 8'h00, 1'b0}, '{1'b1, IDX_CTRL_B, 8'h00, 8'h00, 1'b0},
        '{1'b1, IDX_EV_LO, 8'h03, 8'h00, 1'b0}, '{1'b0, IDX_EV_LO, 8'h00, 8'h03, 1'b0},
        '{1'b0, IDX_EV_MID, 8'h00, 8'h00, 1'b0}};
    // open-drain wires with pull-ups: low while any party pulls
    assign shift_clock_pin_in = !(shift_clock_pin_oe || peer_sck_oe);
    assign serial_data_pin_in = !(serial_data_pin_oe || peer_sda_oe);
    event_serial_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .time_of_day_counter, .shift_clock_pin_in, .shift_clock_pin_out,
        .shift_clock_pin_oe, .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe,
        .alarm_event, .serial_event);
    serial_peer peer (.sck(shift_clock_pin_in), .sda(serial_data_pin_in), .sck_oe(peer_sck_oe),
        .sda_oe(peer_sda_oe), .got(peer_got));
    always #25 pclk = ~pclk;
    // pulse counters update late in the step so waiters never race them
    always @(posedge pclk) begin
        if (alarm_event === 1'b1) n_alarm <= n_alarm + 1;
        if (serial_event === 1'b1) n_ser <= n_ser + 1;
    end
    task automatic close_out();
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_up();
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic wait_n(ref int c, input int t);
        for (int i = 0; i < 600 && c < t; i++) begin
            @(posedge pclk);
        end
        if (c < t) give_up();
    endtask
    // one APB transfer; request held until ready is seen at an edge
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) give_up();
        rd = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [3:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        check({24'h000000, rd}, {24'h000000, e});
    endtask
    // one event pin pulse, long enough for the synchroniser
    task automatic tick();
        time_of_day_counter <= 1'b1;
        repeat (4) @(posedge pclk);
        time_of_day_counter <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].idx, rows[i].d);
            check({24'h000000, rd}, {24'h000000, rows[i].exp});
            check({31'h00000000, rerr}, {31'h00000000, rows[i].err});
        end
        // counter 3 to 5 hits the alarm, then a frozen read while counting goes on
        tick();
        tick();
        wait_n(n_alarm, 1);
        rchk(IDX_EV_HI, 8'h00);
        tick();
        rchk(IDX_EV_LO, 8'h05);
        rchk(IDX_EV_LO, 8'h06);
        xfer(1'b1, IDX_EV_MID, 8'h00);
        tick();
        xfer(1'b1, IDX_EV_HI, 8'hFF);
        xfer(1'b1, IDX_EV_MID, 8'hFF);
        rchk(IDX_EV_LO, 8'h06);
        xfer(1'b1, IDX_EV_LO, 8'hFF);
        tick();
        rchk(IDX_EV_HI, 8'h00);
        rchk(IDX_EV_LO, 8'h00);
        check(n_alarm, 32'h00000001);
        // one byte in from the peer as bus master
        peer.send(8'hA5);
        wait_n(n_ser, 1);
        rchk(IDX_SERIAL, 8'hA5);
        // transmit at pclk/6 with latch 2; second byte queued during the first
        xfer(1'b1, IDX_CTRL_A, 8'h41);
        xfer(1'b1, IDX_SERIAL, 8'h3B);
        repeat (12) @(posedge pclk);
        xfer(1'b1, IDX_SERIAL, 8'hC4);
        wait_n(n_ser, 2);
        for (k = 0; k < 200 && n_ser < 3; k++) begin
            @(posedge pclk);
        end
        check(k, 32'h00000030);
        check({24'h000000, peer_got}, 32'h000000C4);
        repeat (20) @(posedge pclk);
        check({shift_clock_pin_oe, serial_data_pin_oe}, 32'h00000001);
        rchk(IDX_STATUS, 8'h0D);
        // reset in mid-run releases both wires and clears the counter
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({shift_clock_pin_oe, serial_data_pin_oe}, 32'h00000000);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(IDX_EV_LO, 8'h00);
        close_out();
    end
endmodule
